// [design/timer16_channel.sv]
// Purpose: one 16-bit timer channel with AXI4-Lite registers
// Assumes: ext_clk_in is asynchronous; counter counts down
// Notes: underflow is a one-cycle pulse, no interrupt logic
// What this block does
// - four-bit code divides clk_sys by 2**code; code 0xF is reserved.
// - reload value is 16 bits read/write, zero after reset.
// - counter value is read-only, all ones after reset.
// - bit 10 picks external clock active level, high after reset.
// - bits 9:8 pick internal, external or pulse-width source; 3 reserved.
// - bit 4 set means one-shot, clear means repeat; repeat after reset.
// - writing one to bit 1 resets the counter; zero does nothing.
// - bit 0 runs or stops the counter, reads back, stopped after reset.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
module timer16_channel (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ext_clk_in,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic underflow
);
    typedef struct packed {
        logic aw_have;
        logic [31:0] waddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] clock_divide_code;
        logic [15:0] reload_word;
        logic [15:0] count_word;
        logic ext_clock_polarity;
        logic [1:0] count_source_sel;
        logic oneshot_select;
        logic run_control;
        logic [2:0] sync;
        logic ext_level;
        logic ext_prev;
        logic underflow;
    } timer_state_t;

    timer_state_t st;
    timer_state_t next_st;
    logic presc_tick;
    logic do_write;
    logic ar_take;
    logic [15:0] wr_index;
    logic [15:0] rd_index;
    logic wr_ctrl;
    logic clear_wr;
    logic active_now;
    logic active_prev;
    logic count_en;

    function automatic logic [15:0] reg_index(input logic [31:0] addr);
        reg_index = addr[17:2];
    endfunction

    function automatic logic mapped(input logic [31:0] addr);
        logic [15:0] idx;
        idx = addr[17:2];
        mapped = (addr[31:18] == 14'h0000) && (addr[1:0] == 2'h0) &&
            (idx == timer16_pkg::IDX_CLK_SEL || idx == timer16_pkg::IDX_RELOAD ||
             idx == timer16_pkg::IDX_COUNT || idx == timer16_pkg::IDX_CTRL);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
        input logic [3:0] strb);
        merge16 = old;
        if (strb[0]) begin
            merge16[7:0] = data[7:0];
        end
        if (strb[1]) begin
            merge16[15:8] = data[15:8];
        end
    endfunction

    timer16_prescaler i_timer16_prescaler (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clock_divide_code(st.clock_divide_code),
        .tick(presc_tick)
    );

    assign s_axi_awready = !st.aw_have && !st.bvalid;
    assign s_axi_wready = !st.w_have && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign underflow = st.underflow;

    assign do_write = st.aw_have && st.w_have && !st.bvalid;
    assign ar_take = s_axi_arvalid && !st.rvalid;
    assign wr_index = reg_index(st.waddr);
    assign rd_index = reg_index(s_axi_araddr);
    assign wr_ctrl = do_write && mapped(st.waddr) && wr_index == timer16_pkg::IDX_CTRL;
    assign clear_wr = wr_ctrl && st.wstrb[0] && st.wdata[timer16_pkg::CLEAR_BIT];

    assign active_now = st.ext_level == st.ext_clock_polarity;
    assign active_prev = st.ext_prev == st.ext_clock_polarity;

    always_comb begin
        count_en = 1'b0;
        unique case (st.count_source_sel)
            timer16_pkg::SRC_INTERNAL: count_en = presc_tick;
            timer16_pkg::SRC_EXTERNAL: count_en = active_now && !active_prev;
            timer16_pkg::SRC_PULSE: count_en = presc_tick && active_now;
            timer16_pkg::SRC_RESERVED: count_en = 1'b0;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.underflow = 1'b0;

        // external input: three flops, change taken when second and third agree
        next_st.sync = {st.sync[1], st.sync[0], ext_clk_in};
        if (st.sync[1] == st.sync[2]) begin
            next_st.ext_level = st.sync[2];
        end
        next_st.ext_prev = st.ext_level;

        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_have = 1'b1;
            next_st.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_have = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // counter: clear beats counting, underflow reloads
        if (clear_wr) begin
            next_st.count_word = st.reload_word;
        end else if (st.run_control && count_en) begin
            if (st.count_word == 16'h0000) begin
                next_st.count_word = st.reload_word;
                next_st.underflow = 1'b1;
                if (st.oneshot_select) begin
                    next_st.run_control = 1'b0;
                end
            end else begin
                next_st.count_word = st.count_word - 16'h0001;
            end
        end

        if (do_write) begin
            next_st.aw_have = 1'b0;
            next_st.w_have = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = mapped(st.waddr) ? timer16_pkg::RESP_OKAY : timer16_pkg::RESP_SLVERR;
            if (mapped(st.waddr)) begin
                unique case (wr_index)
                    timer16_pkg::IDX_CLK_SEL: begin
                        if (st.wstrb[0]) begin
                            next_st.clock_divide_code = st.wdata[3:0];
                        end
                    end
                    timer16_pkg::IDX_RELOAD: begin
                        next_st.reload_word = merge16(st.reload_word, st.wdata, st.wstrb);
                    end
                    timer16_pkg::IDX_COUNT: begin
                        next_st.count_word = next_st.count_word;
                    end
                    timer16_pkg::IDX_CTRL: begin
                        if (st.wstrb[1]) begin
                            next_st.ext_clock_polarity = st.wdata[timer16_pkg::POL_BIT];
                            next_st.count_source_sel = st.wdata[timer16_pkg::SRC_LO +: 2];
                        end
                        if (st.wstrb[0]) begin
                            next_st.oneshot_select = st.wdata[timer16_pkg::ONESHOT_BIT];
                            next_st.run_control = st.wdata[timer16_pkg::RUN_BIT];
                        end
                    end
                    default: begin
                        next_st.bresp = timer16_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end

        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (ar_take) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = timer16_pkg::RESP_OKAY;
            next_st.rdata = 32'h0000_0000;
            if (!mapped(s_axi_araddr)) begin
                next_st.rresp = timer16_pkg::RESP_SLVERR;
            end else begin
                unique case (rd_index)
                    timer16_pkg::IDX_CLK_SEL: next_st.rdata[3:0] = st.clock_divide_code;
                    timer16_pkg::IDX_RELOAD: next_st.rdata[15:0] = st.reload_word;
                    timer16_pkg::IDX_COUNT: next_st.rdata[15:0] = st.count_word;
                    timer16_pkg::IDX_CTRL: begin
                        next_st.rdata[timer16_pkg::POL_BIT] = st.ext_clock_polarity;
                        next_st.rdata[timer16_pkg::SRC_LO +: 2] = st.count_source_sel;
                        next_st.rdata[timer16_pkg::ONESHOT_BIT] = st.oneshot_select;
                        next_st.rdata[timer16_pkg::RUN_BIT] = st.run_control;
                    end
                    default: begin
                        next_st.rresp = timer16_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st <= '0;
            st.clock_divide_code <= timer16_pkg::CLK_SEL_RST;
            st.reload_word <= timer16_pkg::RELOAD_RST;
            st.count_word <= timer16_pkg::COUNT_RST;
            st.ext_clock_polarity <= timer16_pkg::POL_RST;
            st.count_source_sel <= timer16_pkg::SRC_RST;
            st.oneshot_select <= timer16_pkg::ONESHOT_RST;
            st.run_control <= timer16_pkg::RUN_RST;
        end else begin
            st <= next_st;
        end
    end

    a_reload_write: assert property (@(posedge clk_sys) disable iff (!nrst)
        do_write && wr_index == timer16_pkg::IDX_RELOAD && st.waddr[31:18] == 14'h0000 &&
        st.waddr[1:0] == 2'h0 && st.wstrb[1:0] == 2'h3 |=> st.reload_word == $past(st.wdata[15:0]))
        else $error("reload word did not take written value");

    a_count_read: assert property (@(posedge clk_sys) disable iff (!nrst)
        ar_take && mapped(s_axi_araddr) && rd_index == timer16_pkg::IDX_COUNT
        |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(st.count_word)})
        else $error("counter read does not show counter");

    a_polarity_read: assert property (@(posedge clk_sys) disable iff (!nrst)
        ar_take && mapped(s_axi_araddr) && rd_index == timer16_pkg::IDX_CTRL
        |=> s_axi_rdata[10] == $past(st.ext_clock_polarity) && s_axi_rdata[9:8] == $past(st.count_source_sel))
        else $error("control read mismatch");

    a_source_reserved: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.count_source_sel == 2'h3 && !clear_wr |=> $stable(st.count_word) && !underflow)
        else $error("reserved source counted");

    a_oneshot_stop: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.run_control && st.oneshot_select && count_en && st.count_word == 16'h0000 && !wr_ctrl
        |=> !st.run_control ##1 (!st.run_control || $past(wr_ctrl)))
        else $error("one-shot did not stop at underflow");

    a_clear_loads: assert property (@(posedge clk_sys) disable iff (!nrst)
        clear_wr |=> st.count_word == $past(st.reload_word))
        else $error("counter reset did not load reload word");

    a_stop_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
        !st.run_control && !clear_wr |=> $stable(st.count_word))
        else $error("stopped counter changed");

    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");

    a_ctrl_reserved: assert property (@(posedge clk_sys) disable iff (!nrst)
        ar_take && mapped(s_axi_araddr) && rd_index == timer16_pkg::IDX_CTRL
        |=> s_axi_rdata[15:11] == 5'h00 && s_axi_rdata[7:5] == 3'h0 && s_axi_rdata[3:1] == 3'h0)
        else $error("control reserved bits not zero");

    a_clksel_reserved: assert property (@(posedge clk_sys) disable iff (!nrst)
        ar_take && mapped(s_axi_araddr) && rd_index == timer16_pkg::IDX_CLK_SEL
        |=> s_axi_rdata[15:4] == 12'h000)
        else $error("clock select reserved bits not zero");

    a_read_unmapped: assert property (@(posedge clk_sys) disable iff (!nrst)
        ar_take && !mapped(s_axi_araddr)
        |=> s_axi_rvalid && s_axi_rresp == timer16_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    a_write_slverr: assert property (@(posedge clk_sys) disable iff (!nrst)
        do_write && !mapped(st.waddr)
        |=> s_axi_bvalid && s_axi_bresp == timer16_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");

    a_clksel_write: assert property (@(posedge clk_sys) disable iff (!nrst)
        do_write && mapped(st.waddr) && wr_index == timer16_pkg::IDX_CLK_SEL && st.wstrb[0]
        |=> st.clock_divide_code == $past(st.wdata[3:0]))
        else $error("divide code did not take written value");

    a_ctrl_write: assert property (@(posedge clk_sys) disable iff (!nrst)
        wr_ctrl && st.wstrb[1] |=> st.ext_clock_polarity == $past(st.wdata[timer16_pkg::POL_BIT]) &&
        st.count_source_sel == $past(st.wdata[timer16_pkg::SRC_LO +: 2]))
        else $error("polarity or source not written");

    a_run_write: assert property (@(posedge clk_sys) disable iff (!nrst)
        wr_ctrl && st.wstrb[0] |=> st.run_control == $past(st.wdata[timer16_pkg::RUN_BIT]) &&
        st.oneshot_select == $past(st.wdata[timer16_pkg::ONESHOT_BIT]))
        else $error("run or mode bit not written");

    a_count_step: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.run_control && count_en && st.count_word != 16'h0000 && !clear_wr
        |=> st.count_word == $past(st.count_word) - 16'h0001)
        else $error("running counter did not step down");

    a_pulse_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.run_control && st.count_source_sel == timer16_pkg::SRC_PULSE &&
        st.ext_level != st.ext_clock_polarity && !clear_wr |=> $stable(st.count_word))
        else $error("pulse width counted while input inactive");

    a_underflow_reload: assert property (@(posedge clk_sys) disable iff (!nrst)
        underflow |-> st.count_word == $past(st.reload_word) || $past(clear_wr))
        else $error("underflow did not reload");
endmodule

// [design/timer16_pkg.sv]
// Purpose: shared constants for the 16-bit timer channel
// Assumes: AXI4-Lite data 32 bits, byte address = 4 * register index
// Notes: register indexes are kept as printed
package timer16_pkg;
    localparam logic [15:0] IDX_CLK_SEL = 16'h4260;
    localparam logic [15:0] IDX_RELOAD = 16'h4262;
    localparam logic [15:0] IDX_COUNT = 16'h4264;
    localparam logic [15:0] IDX_CTRL = 16'h4266;

    localparam logic [3:0] CLK_SEL_RST = 4'h0;
    localparam logic [3:0] DIV_RESERVED = 4'hF;
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    localparam logic [15:0] COUNT_RST = 16'hFFFF;
    localparam logic POL_RST = 1'b1;
    localparam logic [1:0] SRC_RST = 2'h0;
    localparam logic ONESHOT_RST = 1'b0;
    localparam logic RUN_RST = 1'b0;

    localparam int POL_BIT = 10;
    localparam int SRC_LO = 8;
    localparam int ONESHOT_BIT = 4;
    localparam int CLEAR_BIT = 1;
    localparam int RUN_BIT = 0;

    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_EXTERNAL = 2'h1;
    localparam logic [1:0] SRC_PULSE = 2'h2;
    localparam logic [1:0] SRC_RESERVED = 2'h3;

    localparam int PRESC_W = 14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [design/timer16_prescaler.sv]
// Purpose: divides clk_sys into a one-cycle count tick
// Assumes: divisor is 2 to the power of the code
// Notes: reserved code gives no tick
`timescale 1ns/1ns
module timer16_prescaler (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [3:0] clock_divide_code,
    output logic tick
);
    typedef struct packed {
        logic [timer16_pkg::PRESC_W-1:0] cnt;
        logic tick;
    } presc_state_t;

    presc_state_t st;
    presc_state_t next_st;
    logic [timer16_pkg::PRESC_W-1:0] mask;
    logic [14:0] mask_full;

    always_comb begin
        next_st = st;
        mask_full = (15'h0001 << clock_divide_code) - 15'h0001;
        mask = mask_full[timer16_pkg::PRESC_W-1:0];
        next_st.cnt = st.cnt + 14'h0001;
        if (clock_divide_code == timer16_pkg::DIV_RESERVED) begin
            next_st.tick = 1'b0;
        end else begin
            next_st.tick = (st.cnt & mask) == mask;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

    a_div_one_tick: assert property (@(posedge clk_sys) disable iff (!nrst)
        nrst && (clock_divide_code == 4'h0) |=> tick)
        else $error("divide by one does not tick every cycle");
    a_div_reserved: assert property (@(posedge clk_sys) disable iff (!nrst)
        (clock_divide_code == 4'hF) |=> !tick)
        else $error("reserved divide code ticked");
endmodule

// [testbench/tb_timer16_channel.sv]
// Purpose: self-checking bench for timer16_channel
// Assumes: byte address is four times the register index
// Notes: random data from an xorshift seeded at 32'h80B2
`timescale 1ns/1ns
module tb_timer16_channel;
    logic clk_sys, nrst, ext_clk_in;
    logic [31:0] awaddr, wdata, araddr, rdata, seed, v, d;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, underflow;
    logic [1:0] bresp, rresp, r;
    int err_total = 0;
    int cmp_count = 0;
    int uf_cnt = 0;
    int u0;

    timer16_channel i_timer16_channel (
        .clk_sys(clk_sys), .nrst(nrst), .ext_clk_in(ext_clk_in),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .underflow(underflow)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // underflow pulse counter
    always @(posedge clk_sys) begin
        if (underflow === 1'b1) uf_cnt <= uf_cnt + 1;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] ba(input logic [15:0] idx);
        return {14'h0, idx, 2'b00};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] dat, output logic [1:0] rs);
        @(posedge clk_sys);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= dat;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] dat, output logic [1:0] rs);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        dat = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic wreg(input logic [15:0] idx, input logic [31:0] dat);
        logic [1:0] rs;
        wr(ba(idx), dat, rs);
        chk("bresp", 32'(timer16_pkg::RESP_OKAY), 32'(rs));
    endtask

    task automatic rreg(input string what, input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] got;
        logic [1:0] rs;
        rd(ba(idx), got, rs);
        chk("rresp", 32'(timer16_pkg::RESP_OKAY), 32'(rs));
        chk(what, exp, got);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        wrap_up();
    end

    initial begin
        seed = 32'h80B2;
        {nrst, ext_clk_in, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr, wstrb} = '0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        rreg("clk_sel rst", timer16_pkg::IDX_CLK_SEL, 32'h0);
        rreg("reload rst", timer16_pkg::IDX_RELOAD, 32'h0);
        rreg("count rst", timer16_pkg::IDX_COUNT, 32'hFFFF);
        rreg("ctrl rst", timer16_pkg::IDX_CTRL, 32'h0400);
        for (int i = 0; i < 16; i++) begin
            wreg(timer16_pkg::IDX_CLK_SEL, (rnd() & 32'hFFFF_FFF0) | 32'(i));
            rreg("clk_sel", timer16_pkg::IDX_CLK_SEL, 32'(i));
        end
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 32'hFFFF : (i == 1) ? 32'h0 : rnd();
            wreg(timer16_pkg::IDX_RELOAD, v);
            rreg("reload", timer16_pkg::IDX_RELOAD, v & 32'hFFFF);
        end
        for (int i = 0; i < 4; i++) begin
            v = (rnd() & ~32'h0000_0311) | (32'(i) << 8);
            wreg(timer16_pkg::IDX_CTRL, v);
            rreg("ctrl", timer16_pkg::IDX_CTRL, v & 32'h0711);
        end
        wreg(timer16_pkg::IDX_RELOAD, 32'h5);
        wreg(timer16_pkg::IDX_CLK_SEL, 32'h0);
        wreg(timer16_pkg::IDX_CTRL, 32'h2);
        rreg("count clear", timer16_pkg::IDX_COUNT, 32'h5);
        wreg(timer16_pkg::IDX_COUNT, 32'h1234);
        rreg("count ro", timer16_pkg::IDX_COUNT, 32'h5);
        u0 = uf_cnt;
        wreg(timer16_pkg::IDX_CTRL, 32'h11);
        repeat (40) @(posedge clk_sys);
        rreg("oneshot stop", timer16_pkg::IDX_CTRL, 32'h10);
        rreg("oneshot count", timer16_pkg::IDX_COUNT, 32'h5);
        chk("oneshot underflows", 32'h1, 32'(uf_cnt - u0));
        wreg(timer16_pkg::IDX_RELOAD, 32'h3);
        wreg(timer16_pkg::IDX_CLK_SEL, 32'h3);
        wreg(timer16_pkg::IDX_CTRL, 32'h2);
        u0 = uf_cnt;
        wreg(timer16_pkg::IDX_CTRL, 32'h1);
        repeat (800) @(posedge clk_sys);
        rreg("repeat run", timer16_pkg::IDX_CTRL, 32'h1);
        wreg(timer16_pkg::IDX_CTRL, 32'h0);
        chk("div8 rate", 32'h1, 32'((uf_cnt - u0) >= 24 && (uf_cnt - u0) <= 26));
        wreg(timer16_pkg::IDX_CLK_SEL, 32'hF);
        wreg(timer16_pkg::IDX_CTRL, 32'h2);
        wreg(timer16_pkg::IDX_CTRL, 32'h1);
        repeat (200) @(posedge clk_sys);
        wreg(timer16_pkg::IDX_CTRL, 32'h0);
        rreg("reserved div", timer16_pkg::IDX_COUNT, 32'h3);
        wreg(timer16_pkg::IDX_RELOAD, 32'd100);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_sys);
            ext_clk_in <= ~p[0];
            wreg(timer16_pkg::IDX_CTRL, (32'(p) << 10) | 32'h0102);
            wreg(timer16_pkg::IDX_CTRL, (32'(p) << 10) | 32'h0101);
            for (int k = 0; k < 6; k++) begin
                @(posedge clk_sys);
                ext_clk_in <= p[0];
                repeat (4) @(posedge clk_sys);
                ext_clk_in <= ~p[0];
                repeat (3) @(posedge clk_sys);
            end
            repeat (8) @(posedge clk_sys);
            wreg(timer16_pkg::IDX_CTRL, 32'h0);
            rreg("ext edges", timer16_pkg::IDX_COUNT, 32'd94);
        end
        wreg(timer16_pkg::IDX_CLK_SEL, 32'h0);
        @(posedge clk_sys);
        ext_clk_in <= 1'b0;
        wreg(timer16_pkg::IDX_CTRL, 32'h0602);
        wreg(timer16_pkg::IDX_CTRL, 32'h0601);
        repeat (10) @(posedge clk_sys);
        ext_clk_in <= 1'b1;
        repeat (20) @(posedge clk_sys);
        ext_clk_in <= 1'b0;
        repeat (8) @(posedge clk_sys);
        wreg(timer16_pkg::IDX_CTRL, 32'h0);
        rd(ba(timer16_pkg::IDX_COUNT), d, r);
        chk("pulse width", 32'h1, 32'(d >= 32'd78 && d <= 32'd82));
        wreg(timer16_pkg::IDX_CTRL, 32'h0302);
        wreg(timer16_pkg::IDX_CTRL, 32'h0301);
        repeat (20) @(posedge clk_sys);
        wreg(timer16_pkg::IDX_CTRL, 32'h0);
        rreg("reserved src", timer16_pkg::IDX_COUNT, 32'd100);
        rd(ba(16'h4268), d, r);
        chk("unmapped rresp", 32'(timer16_pkg::RESP_SLVERR), 32'(r));
        chk("unmapped rdata", 32'h0, d);
        wr(ba(timer16_pkg::IDX_CTRL) + 32'h2, 32'h1, r);
        chk("misaligned bresp", 32'(timer16_pkg::RESP_SLVERR), 32'(r));
        rreg("ctrl kept", timer16_pkg::IDX_CTRL, 32'h0);
        wrap_up();
    end
endmodule
